// File: fcrcs_pkg.sv
package fcrcs_pkg;
	// ======================================================
	// register map
	localparam logic [15:0] REG_CTRL_A_OFF = 16'h0000;
	localparam logic [15:0] REG_CTRL_B_OFF = 16'h0004;
	localparam logic [15:0] ARRAY_BASE = 16'h1000;
	localparam int A_READY_POS = 0;
	localparam int A_REWRITE_POS = 1;
	localparam int A_BOOT_POS = 2;
	localparam int A_PERR_POS = 6;
	localparam int A_EERR_POS = 7;
	localparam int B_SUBMODE_POS = 1;
	localparam int SR_READY_POS = 7;
	localparam int SR_EERR_POS = 5;
	localparam int SR_PERR_POS = 4;
	localparam logic READY_RST = 1'b1;
	localparam logic FLAG_RST = 1'b0;
	// ======================================================
	// command codes, low byte only
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;
	// ======================================================
	// array geometry and timing
	localparam int ARRAY_WORDS = 64;
	localparam int BLOCK_WORDS = 16;
	localparam int BOOT_BLOCKS = 2;
	localparam int CLK_PERIOD_NS = 40;
	localparam int PROG_TIME_NS = 2000;
	localparam int ERASE_TIME_NS = 40000;
	localparam int PROG_CYCLES =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_CYCLES =
		(ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ======================================================
	// types
	typedef enum logic [1:0] {
		SEQ_IDLE, SEQ_PROG2, SEQ_ERASE2, SEQ_BUSY
	} fcrcs_seq_e;
	typedef enum logic {RD_ARRAY, RD_STATUS} fcrcs_read_e;
	typedef struct packed {
		logic ready;
		logic erase_err;
		logic prog_err;
	} fcrcs_flags_s;
endpackage : fcrcs_pkg

// File: fcrcs_unlock_bit.sv
`timescale 1ns/1ps
module fcrcs_unlock_bit
	import fcrcs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clr,
	input wire logic brk,
	input wire logic wr_en,
	input wire logic wr_val,
	output logic set_r
);
	// ======================================================
	// zero then one sets the bit; any other write disarms
	logic armed_r;
	logic armed_nxt;
	logic set_nxt;
	assign armed_nxt = wr_en ? ~wr_val : (armed_r & ~brk);
	assign set_nxt = wr_en ? (wr_val & (armed_r | set_r)) : set_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 1'b0;
			set_r <= 1'b0;
		end else if (clr) begin
			armed_r <= 1'b0;
			set_r <= 1'b0;
		end else begin
			armed_r <= armed_nxt;
			set_r <= set_nxt;
		end
	end
endmodule : fcrcs_unlock_bit

// File: fcrcs_op_timer.sv
`timescale 1ns/1ps
module fcrcs_op_timer
	import fcrcs_pkg::*;
#(
	parameter int CNT_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic abort,
	input wire logic start,
	input wire logic [CNT_W-1:0] load,
	output logic busy,
	output logic done
);
	// ======================================================
	// down counter standing in for the array's own timing
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	assign cnt_nxt = abort ? '0 : start ? load :
		(cnt_r != '0) ? cnt_r - CNT_W'(1) : cnt_r;
	assign busy = cnt_r != '0;
	assign done = (cnt_r == CNT_W'(1)) & ~abort;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : fcrcs_op_timer

// File: fcrcs_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - commands are 16-bit words at even addresses; upper byte ignored.
// - FF enters array read mode, kept until another command.
// - 70 makes following array-area reads return status.
// - 50 clears program and erase error flags everywhere.
// - 40 then data write starts auto program with verify.
// - ready flag is zero during auto operations, one after.
// - program outcome lands in the program error flag.
// - boot blocks 0 and 1 refuse program/erase unless enabled.
// - ram-resident program start enters status read mode.
// - 20 then D0 at a block's top word erases that block.
// - erase outcome lands in the erase error flag.
// - ram-resident erase enters status read mode until read command.
// - enable bits set only by zero write then one write.
// - NMI or watchdog reinitialises control and aborts rewrite.
// - set error flags reject program and erase commands.
// - bad erase confirm code sets both error flags.
// - FF in a second cycle cancels and enters array read.
module fcrcs_sequencer
	import fcrcs_pkg::*;
#(
	parameter int DEPTH = ARRAY_WORDS,
	parameter int BLK_WORDS = BLOCK_WORDS,
	parameter int PROG_CNT = PROG_CYCLES,
	parameter int ERASE_CNT = ERASE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic nmi_wdt_event,
	output logic seq_ready_flag
);
	localparam int IDX_W = $clog2(DEPTH);
	localparam int BLK_SH = $clog2(BLK_WORDS);
	localparam int BLK_W = IDX_W - BLK_SH;
	localparam int CNT_W = $clog2(ERASE_CNT + 1);
	localparam int PCYC = PROG_CNT;
	localparam logic [15:0] ARRAY_END = ARRAY_BASE + 16'(DEPTH * 4);

	// ======================================================
	// state
	fcrcs_seq_e seq_r;
	fcrcs_seq_e seq_nxt;
	fcrcs_read_e rmode_r;
	fcrcs_read_e rmode_nxt;
	fcrcs_flags_s flags;
	logic [15:0] mem_r [DEPTH];
	logic [IDX_W-1:0] tgt_r;
	logic [IDX_W-1:0] tgt_nxt;
	logic [15:0] data_r;
	logic [15:0] data_nxt;
	logic op_erase_r;
	logic op_erase_nxt;
	logic perr_r;
	logic eerr_r;
	logic [31:0] prdata_r;
	logic rewrite_en;
	logic boot_en;
	logic submode_flash;
	logic busy;
	logic op_done;

	// ======================================================
	// APB decode
	logic apb_acc;
	logic wr_acc;
	logic rd_setup;
	logic hit_a;
	logic hit_b;
	logic hit_arr;
	logic unmapped;
	logic wr_a_lo;
	logic wr_b_lo;
	logic cmd_wr;
	logic any_err;
	logic blk_prot;
	logic blk_top;
	logic [15:0] arr_off;
	logic [IDX_W-1:0] cmd_idx;
	logic [7:0] cmd_code;
	logic [7:0] status_byte;
	logic [31:0] ctrl_a_word;
	logic [31:0] ctrl_b_word;
	logic [31:0] rd_word;

	assign apb_acc = psel & penable;
	assign wr_acc = apb_acc & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit_a = paddr == REG_CTRL_A_OFF;
	assign hit_b = paddr == REG_CTRL_B_OFF;
	assign hit_arr = (paddr >= ARRAY_BASE) && (paddr < ARRAY_END)
		&& (paddr[1:0] == 2'h0);
	assign unmapped = ~(hit_a | hit_b | hit_arr);
	// zero wait states: read data is caught in the setup cycle
	assign pready = 1'b1;
	assign pslverr = apb_acc & unmapped;
	assign prdata = prdata_r;
	assign wr_a_lo = wr_acc & hit_a & pstrb[0];
	assign wr_b_lo = wr_acc & hit_b & pstrb[0];
	assign arr_off = paddr - ARRAY_BASE;
	assign cmd_idx = arr_off[IDX_W+1:2];
	assign cmd_code = pwdata[7:0];
	// half-word writes only; a lone byte lane is dropped
	assign cmd_wr = wr_acc & hit_arr & (pstrb[1:0] == 2'h3)
		& rewrite_en;
	assign any_err = perr_r | eerr_r;
	assign blk_prot = ~boot_en
		& (cmd_idx[IDX_W-1:BLK_SH] < BLK_W'(BOOT_BLOCKS));
	assign blk_top = &cmd_idx[BLK_SH-1:0];
	assign flags.ready = ~busy;
	assign flags.erase_err = eerr_r;
	assign flags.prog_err = perr_r;
	assign seq_ready_flag = flags.ready;

	// ======================================================
	// enable bits
	fcrcs_unlock_bit u_rewrite (
		.pclk(pclk),
		.presetn(presetn),
		.clr(nmi_wdt_event),
		.brk(wr_acc & ~wr_a_lo),
		.wr_en(wr_a_lo),
		.wr_val(pwdata[A_REWRITE_POS]),
		.set_r(rewrite_en)
	);
	fcrcs_unlock_bit u_boot (
		.pclk(pclk),
		.presetn(presetn),
		.clr(nmi_wdt_event | ~rewrite_en),
		.brk(wr_acc & ~wr_a_lo),
		.wr_en(wr_a_lo & rewrite_en),
		.wr_val(pwdata[A_BOOT_POS]),
		.set_r(boot_en)
	);
	fcrcs_unlock_bit u_submode (
		.pclk(pclk),
		.presetn(presetn),
		.clr(nmi_wdt_event),
		.brk(wr_acc & ~wr_b_lo),
		.wr_en(wr_b_lo),
		.wr_val(pwdata[B_SUBMODE_POS]),
		.set_r(submode_flash)
	);

	// ======================================================
	// command sequencer
	logic start_prog;
	logic start_erase;
	logic seq_err;
	logic clr_err;
	logic prog_fail;
	logic perr_set;
	logic eerr_set;

	always_comb begin
		seq_nxt = seq_r;
		rmode_nxt = rmode_r;
		tgt_nxt = tgt_r;
		data_nxt = data_r;
		op_erase_nxt = op_erase_r;
		start_prog = 1'b0;
		start_erase = 1'b0;
		seq_err = 1'b0;
		clr_err = 1'b0;
		case (seq_r)
			SEQ_IDLE: begin
				if (cmd_wr) begin
					case (cmd_code)
						CMD_READ_ARRAY: rmode_nxt = RD_ARRAY;
						CMD_READ_STATUS: rmode_nxt = RD_STATUS;
						CMD_CLEAR_STATUS: clr_err = 1'b1;
						CMD_PROGRAM: begin
							if (!any_err) seq_nxt = SEQ_PROG2;
						end
						CMD_ERASE: begin
							if (!any_err) seq_nxt = SEQ_ERASE2;
						end
						default: ;
					endcase
				end
			end
			SEQ_PROG2: begin
				if (cmd_wr) begin
					seq_nxt = SEQ_IDLE;
					if (cmd_code == CMD_READ_ARRAY) begin
						rmode_nxt = RD_ARRAY;
					end else if (blk_prot) begin
						seq_err = 1'b1;
					end else begin
						// second-cycle address wins over the first
						tgt_nxt = cmd_idx;
						data_nxt = pwdata[15:0];
						op_erase_nxt = 1'b0;
						start_prog = 1'b1;
						seq_nxt = SEQ_BUSY;
						if (!submode_flash) rmode_nxt = RD_STATUS;
					end
				end
			end
			SEQ_ERASE2: begin
				if (cmd_wr) begin
					seq_nxt = SEQ_IDLE;
					if (cmd_code == CMD_READ_ARRAY) begin
						rmode_nxt = RD_ARRAY;
					end else if (cmd_code != CMD_ERASE_CONFIRM
						|| !blk_top || blk_prot) begin
						seq_err = 1'b1;
					end else begin
						tgt_nxt = cmd_idx;
						op_erase_nxt = 1'b1;
						start_erase = 1'b1;
						seq_nxt = SEQ_BUSY;
						if (!submode_flash) rmode_nxt = RD_STATUS;
					end
				end
			end
			SEQ_BUSY: begin
				// commands during an auto operation are dropped
				if (op_done) seq_nxt = SEQ_IDLE;
			end
			default: seq_nxt = SEQ_IDLE;
		endcase
	end

	fcrcs_op_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.abort(nmi_wdt_event),
		.start(start_prog | start_erase),
		.load(start_erase ? CNT_W'(ERASE_CNT) : CNT_W'(PROG_CNT)),
		.busy(busy),
		.done(op_done)
	);

	// verify: programming can only clear bits, so a word whose
	// ones cannot be reached reports failure; erase always verifies
	assign prog_fail = (mem_r[tgt_r] & data_r) != data_r;
	assign perr_set = seq_err
		| (op_done & ~op_erase_r & prog_fail);
	assign eerr_set = seq_err;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_r <= SEQ_IDLE;
			rmode_r <= RD_ARRAY;
			tgt_r <= '0;
			data_r <= '0;
			op_erase_r <= 1'b0;
		end else if (nmi_wdt_event) begin
			seq_r <= SEQ_IDLE;
			rmode_r <= RD_ARRAY;
			op_erase_r <= 1'b0;
		end else begin
			seq_r <= seq_nxt;
			rmode_r <= rmode_nxt;
			tgt_r <= tgt_nxt;
			data_r <= data_nxt;
			op_erase_r <= op_erase_nxt;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			perr_r <= FLAG_RST;
			eerr_r <= FLAG_RST;
		end else if (nmi_wdt_event) begin
			perr_r <= FLAG_RST;
			eerr_r <= FLAG_RST;
		end else begin
			perr_r <= (perr_r & ~clr_err) | perr_set;
			eerr_r <= (eerr_r & ~clr_err) | eerr_set;
		end
	end

	// ======================================================
	// array model: flops stand in for flash, so reset reads erased
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= ERASED_WORD;
			end
		end else if (op_done && !op_erase_r) begin
			mem_r[tgt_r] <= mem_r[tgt_r] & data_r;
		end else if (op_done) begin
			for (int i = 0; i < DEPTH; i++) begin
				if ((IDX_W'(i) >> BLK_SH) == (tgt_r >> BLK_SH)) begin
					mem_r[i] <= ERASED_WORD;
				end
			end
		end
	end

	// ======================================================
	// read data
	always_comb begin
		status_byte = 8'h00;
		status_byte[SR_READY_POS] = flags.ready;
		status_byte[SR_EERR_POS] = flags.erase_err;
		status_byte[SR_PERR_POS] = flags.prog_err;
		ctrl_a_word = 32'h00000000;
		ctrl_a_word[A_READY_POS] = flags.ready;
		ctrl_a_word[A_REWRITE_POS] = rewrite_en;
		ctrl_a_word[A_BOOT_POS] = boot_en;
		ctrl_a_word[A_PERR_POS] = flags.prog_err;
		ctrl_a_word[A_EERR_POS] = flags.erase_err;
		ctrl_b_word = 32'h00000000;
		ctrl_b_word[B_SUBMODE_POS] = submode_flash;
	end

	assign rd_word = hit_a ? ctrl_a_word : hit_b ? ctrl_b_word :
		!hit_arr ? 32'h00000000 :
		(rmode_r == RD_STATUS && rewrite_en) ?
		{24'h000000, status_byte} :
		{16'h0000, mem_r[cmd_idx]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_r <= rd_word;
		end
	end

	// ======================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_prog_run;
		##PCYC !seq_ready_flag ##1 seq_ready_flag;
	endsequence

	sequence s_cancelled;
		seq_r == SEQ_IDLE && rmode_r == RD_ARRAY && seq_ready_flag;
	endsequence

	// an abort legally ends the busy time early
	a_busy_ready: assert property (
		seq_r == SEQ_BUSY && !op_done && !nmi_wdt_event
		|=> !seq_ready_flag)
		else $error("ready flag high during auto operation");

	a_prog_time: assert property (
		start_prog && !nmi_wdt_event |-> s_prog_run)
		else $error("program busy time wrong");

	a_erase_busy: assert property (
		start_erase && !nmi_wdt_event |-> ##1 !seq_ready_flag [*8])
		else $error("erase did not hold busy");

	a_seq_err: assert property (
		seq_err && !nmi_wdt_event |=> perr_r && eerr_r)
		else $error("sequence error did not set both flags");

	a_clear_flags: assert property (
		clr_err && !perr_set && !nmi_wdt_event |=> !perr_r && !eerr_r)
		else $error("clear status left a flag set");

	a_err_reject: assert property (
		seq_r == SEQ_IDLE && cmd_wr && any_err && !nmi_wdt_event
		&& (cmd_code == CMD_PROGRAM || cmd_code == CMD_ERASE)
		|=> seq_r == SEQ_IDLE)
		else $error("command accepted with error flag set");

	a_boot_guard: assert property (
		seq_r == SEQ_PROG2 && cmd_wr && blk_prot && !nmi_wdt_event
		&& cmd_code != CMD_READ_ARRAY
		|=> seq_r == SEQ_IDLE && seq_ready_flag && perr_r && eerr_r)
		else $error("protected block was not refused");

	a_status_mode: assert property (
		(start_prog || start_erase) && !submode_flash && !nmi_wdt_event
		|=> rmode_r == RD_STATUS && !seq_ready_flag)
		else $error("status mode not entered at start");

	a_cancel_ff: assert property (
		(seq_r == SEQ_PROG2 || seq_r == SEQ_ERASE2) && cmd_wr
		&& cmd_code == CMD_READ_ARRAY && !nmi_wdt_event
		|=> s_cancelled)
		else $error("FF in second cycle did not cancel");

	a_reinit: assert property (
		nmi_wdt_event |=> s_cancelled and (!rewrite_en && !perr_r))
		else $error("reinitialise left state behind");

	a_upper_ignored: assert property (
		rd_setup && hit_arr && rmode_r == RD_STATUS && rewrite_en
		|=> prdata[31:8] == 24'h000000)
		else $error("status read carries upper bits");
endmodule : fcrcs_sequencer

// File: fcrcs_cpu_model.sv
`timescale 1ns/1ps
// ======================================================
// cpu side: apb master issuing flash commands and reads
// stands for software that slowed the bus and set the wait state
// no dma engine here, so nothing steals the bus while busy
// never enters wait or stop mode, so rewrite enable may stay set
module fcrcs_cpu_model
	import fcrcs_pkg::*;
(
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end
	// whole 16-bit words only, so strobes stay full
	task automatic xfer(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows inverted values, never a stale match
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : fcrcs_cpu_model

// File: fcrcs_sequencer_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
	end end
module fcrcs_sequencer_tb_top
	import fcrcs_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic nmi_wdt_event = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, seq_ready_flag;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	localparam logic [15:0] CA = REG_CTRL_A_OFF;
	localparam logic [15:0] CB = REG_CTRL_B_OFF;
	always #20 pclk = ~pclk;
	// ======================================================
	// small counts keep the auto operations short
	fcrcs_sequencer #(.PROG_CNT(4), .ERASE_CNT(20)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.nmi_wdt_event(nmi_wdt_event), .seq_ready_flag(seq_ready_flag));
	fcrcs_cpu_model cpu (
		.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb));
	// ======================================================
	// helpers
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		cpu.xfer(1'b1, a, d, q, e);
	endtask : wr
	task automatic chk_rd(input logic [15:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		cpu.xfer(1'b0, a, 32'h0, q, e);
		`CHK(q, x)
	endtask : chk_rd
	task automatic prog(input logic [15:0] a, input logic [31:0] d);
		wr(a, 32'h00000040);
		wr(a, d);
	endtask : prog
	task automatic wait_rdy();
		logic [31:0] q;
		logic e;
		q = 32'h0;
		while (q[A_READY_POS] !== 1'b1) begin
			cpu.xfer(1'b0, CA, 32'h0, q, e);
		end
	endtask : wait_rdy
	task automatic results();
		if (n_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// ======================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		chk_rd(CA, 32'h00000001);
		chk_rd(CB, 32'h00000000);
		chk_rd(16'h1080, 32'h0000FFFF);
		cpu.xfer(1'b0, 16'h0800, 32'h0, q, e);
		`CHK(e, 1'b1)
	endtask : t_reset
	task automatic t_unlock();
		wr(CA, 32'h00000002);
		chk_rd(CA, 32'h00000001);
		wr(CA, 32'h00000000);
		wr(CB, 32'h00000000);
		wr(CA, 32'h00000002);
		chk_rd(CA, 32'h00000001);
		wr(CA, 32'h00000000);
		wr(CA, 32'h00000002);
		chk_rd(CA, 32'h00000003);
	endtask : t_unlock
	task automatic t_program();
		wr(16'h1080, 32'h0000AB40);
		wr(16'h1080, 32'h00001234);
		chk_rd(CA, 32'h00000002);
		wait_rdy();
		chk_rd(16'h1084, 32'h00000080);
		chk_rd(CA, 32'h00000003);
		for (int i = 0; i < 4; i++) begin
			wr(16'h1090 + 16'(4 * i), 32'h000000FF);
		end
		chk_rd(16'h1090, 32'h0000FFFF);
		chk_rd(16'h1094, 32'h0000FFFF);
		chk_rd(16'h1080, 32'h00001234);
	endtask : t_program
	task automatic t_prog_err();
		// overwriting a programmed word is the only way to fail verify
		prog(16'h1080, 32'h00005678);
		wait_rdy();
		chk_rd(CA, 32'h00000043);
		wr(16'h1088, 32'h00000070);
		chk_rd(16'h1088, 32'h00000090);
		prog(16'h1084, 32'h000000FF);
		chk_rd(CA, 32'h00000043);
		chk_rd(16'h1084, 32'h0000FFFF);
		wr(16'h1084, 32'h00000050);
		chk_rd(CA, 32'h00000003);
	endtask : t_prog_err
	task automatic t_erase();
		wr(16'h1080, 32'h00000020);
		wr(16'h10BC, 32'h000055D0);
		chk_rd(CA, 32'h00000002);
		wait_rdy();
		chk_rd(16'h1080, 32'h00000080);
		chk_rd(CA, 32'h00000003);
		wr(16'h1080, 32'h000000FF);
		chk_rd(16'h1080, 32'h0000FFFF);
		prog(16'h1080, 32'h0000ABCD);
		wait_rdy();
		chk_rd(CA, 32'h00000003);
		wr(16'h1080, 32'h000000FF);
		chk_rd(16'h1080, 32'h0000ABCD);
	endtask : t_erase
	task automatic t_boot();
		prog(16'h1000, 32'h00005A5A);
		chk_rd(CA, 32'h000000C3);
		wr(16'h1000, 32'h00000050);
		wr(16'h1080, 32'h00000020);
		wr(16'h10BC, 32'h00000011);
		chk_rd(CA, 32'h000000C3);
		wr(16'h1000, 32'h00000050);
		wr(16'h1080, 32'h00000020);
		wr(16'h10BC, 32'h000000FF);
		chk_rd(CA, 32'h00000003);
		chk_rd(16'h1000, 32'h0000FFFF);
		wr(CA, 32'h00000002);
		wr(CA, 32'h00000006);
		chk_rd(CA, 32'h00000007);
		prog(16'h1000, 32'h00005A5A);
		wait_rdy();
		chk_rd(CA, 32'h00000007);
		wr(16'h1000, 32'h000000FF);
		chk_rd(16'h1000, 32'h00005A5A);
	endtask : t_boot
	task automatic t_nmi();
		wr(CB, 32'h00000000);
		wr(CB, 32'h00000002);
		chk_rd(CB, 32'h00000002);
		// flash-resident from here: no status command is issued
		wr(16'h10F0, 32'h00000020);
		wr(16'h10FC, 32'h000000D0);
		// strike mid-erase, once the guarded busy window has passed
		repeat (8) @(posedge pclk);
		`CHK(seq_ready_flag, 1'b0)
		nmi_wdt_event <= 1'b1;
		@(posedge pclk);
		nmi_wdt_event <= 1'b0;
		chk_rd(CA, 32'h00000001);
		chk_rd(CB, 32'h00000000);
		chk_rd(16'h1000, 32'h00005A5A);
	endtask : t_nmi
	// ======================================================
	// main sequence and hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		// a lost ready flag must not hang the run
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_unlock();
		t_program();
		t_prog_err();
		t_erase();
		t_boot();
		t_nmi();
		results();
	end
endmodule : fcrcs_sequencer_tb_top
